// ---- include/chip_select_pkg.sv ----
// ----------------------------------------------------------------------------
// shared constants for the chip-select block
// ----------------------------------------------------------------------------
package chip_select_pkg;

    // ------------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------------
    localparam int CH_COUNT      = 12;   // boot channel plus eleven selects
    localparam int PORT_BITS     = 7;    // discrete output port data bits
    localparam int DISCRETE_BASE = 4;    // first channel whose pin has a port bit
    localparam int IDX_W         = 4;    // width of a channel index
    localparam int ADDR_W        = 24;   // internal address bus
    localparam int WB_ADR_W      = 8;    // wishbone byte address width

    // ------------------------------------------------------------------------
    // base register layout
    // ------------------------------------------------------------------------
    localparam int BASE_ADDR_LO   = 3;   // base bits [15:3] hold address lines
    localparam int BASE_LINE_LO   = 11;  // lowest address line in the base field
    localparam int BASE_SIZE_LO   = 0;   // block size code in [2:0]
    localparam int SIZE_W         = 3;
    localparam int SIZE_LOW_BIT [8] = '{11, 13, 14, 16, 17, 18, 19, 20};

    // ------------------------------------------------------------------------
    // option register layout
    // ------------------------------------------------------------------------
    localparam int OPT_MODE_BIT  = 15;
    localparam int OPT_BYTE_LO   = 13;
    localparam int OPT_DIR_LO    = 11;
    localparam int OPT_STROBE_CHOICE_BIT  = 10;
    localparam int OPT_ACK_LO    = 6;
    localparam int OPT_SPACE_LO  = 4;
    localparam int OPT_IPL_LO    = 1;
    localparam int OPT_AUTOVECTOR_RESPONSE_BIT  = 0;
    localparam int ACK_W         = 4;
    localparam int IPL_W         = 3;
    localparam int IACK_LEVEL_LO = 1;    // interrupt level on address [3:1]

    // ------------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------------
    localparam logic [1:0] BYTE_LOWER   = 2'h1;
    localparam logic [1:0] BYTE_UPPER   = 2'h2;
    localparam logic [1:0] BYTE_BOTH    = 2'h3;
    localparam logic [1:0] DIR_READ     = 2'h1;
    localparam logic [1:0] DIR_WRITE    = 2'h2;
    localparam logic [1:0] DIR_BOTH     = 2'h3;
    localparam logic [1:0] SPACE_CPU    = 2'h0;
    localparam logic [1:0] SPACE_USER   = 2'h1;
    localparam logic [1:0] SPACE_SUPER  = 2'h2;
    localparam logic [1:0] SPACE_EITHER = 2'h3;
    localparam logic [3:0] ACK_FAST     = 4'he;
    localparam logic [3:0] ACK_EXTERNAL = 4'hf;
    localparam logic [3:0] COUNT_MAX    = 4'hf;
    localparam logic [2:0] IPL_ANY      = 3'h0;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [15:0] BOOT_BASE_RESET = 16'h0007;
    localparam logic [15:0] BOOT_OPT_RESET  = 16'h7b70;
    localparam logic [15:0] BASE_RESET      = 16'h0000;
    localparam logic [15:0] OPT_RESET       = 16'h0000;
    localparam logic [6:0]  PORT_RESET      = 7'h7f;

    // ------------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------------
    localparam int          REG_STRIDE_SHIFT = 3;      // 8 bytes per channel
    localparam logic [WB_ADR_W-1:0] REG_PORT   = 8'h60;
    localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h64;
    localparam int          REG_OPT_BIT      = 2;      // address bit 2 picks options
    localparam int          STAT_DATA_SIZE_ACKNOWLEDGE_BIT   = 16;
    localparam int          STAT_AUTOVECTOR_RESPONSE_BIT    = 17;
    localparam int          STAT_PENDING_BIT = 18;

endpackage

// ---- hw/chip_select_channel.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// one channel: address compare and option qualification, no state
// ----------------------------------------------------------------------------
module chip_select_channel (
    // channel settings
    input  wire logic [15:0]                        i_base,
    input  wire logic [15:0]                        i_options,
    input  wire logic                               i_port16,
    // current access
    input  wire logic [chip_select_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                               i_read,
    input  wire logic [1:0]                         i_space,
    input  wire logic                               i_iack,
    input  wire logic                               i_upper_lane,
    input  wire logic                               i_lower_lane,
    // result
    output logic                                    o_match
);
    import chip_select_pkg::*;

    logic       addr_hit;   // compared lines all equal
    logic       byte_ok;    // byte lane qualification
    logic       dir_ok;     // read/write qualification
    logic       space_ok;   // address space and level qualification
    logic [1:0] byte_code;
    logic [1:0] dir_code;
    logic [1:0] space_code;
    logic [2:0] level_code;
    logic [2:0] size_code;

    // ------------------------------------------------------------------------
    // combinational match
    // ------------------------------------------------------------------------
    always_comb begin
        size_code  = i_base[BASE_SIZE_LO +: SIZE_W];
        byte_code  = i_options[OPT_BYTE_LO +: 2];
        dir_code   = i_options[OPT_DIR_LO +: 2];
        space_code = i_options[OPT_SPACE_LO +: 2];
        level_code = i_options[OPT_IPL_LO +: IPL_W];
        // only the lines at or above the block size are compared
        addr_hit = 1'b1;
        for (int b = BASE_ADDR_LO; b < 16; b++) begin
            if (b - BASE_ADDR_LO + BASE_LINE_LO >= SIZE_LOW_BIT[size_code]) begin
                if (i_base[b] != i_addr[b - BASE_ADDR_LO + BASE_LINE_LO]) begin
                    addr_hit = 1'b0;
                end
            end
        end
        // an 8-bit port selects on every address of the block
        if (i_port16) begin
            byte_ok = ((byte_code == BYTE_LOWER) && i_lower_lane) ||
                      ((byte_code == BYTE_UPPER) && i_upper_lane) ||
                      (byte_code == BYTE_BOTH);
        end else begin
            byte_ok = 1'b1;
        end
        // reserved direction code never asserts
        dir_ok = ((dir_code == DIR_READ) && i_read) ||
                 ((dir_code == DIR_WRITE) && !i_read) ||
                 (dir_code == DIR_BOTH);
        // cpu space only answers an interrupt acknowledge at the right level
        unique case (space_code)
            SPACE_CPU: begin
                space_ok = i_iack && (i_space == SPACE_CPU) &&
                           ((level_code == IPL_ANY) ||
                            (level_code == i_addr[IACK_LEVEL_LO +: IPL_W]));
            end
            SPACE_USER: begin
                space_ok = (i_space == SPACE_USER);
            end
            SPACE_SUPER: begin
                space_ok = (i_space == SPACE_SUPER);
            end
            SPACE_EITHER: begin
                space_ok = (i_space == SPACE_USER) || (i_space == SPACE_SUPER);
            end
        endcase
        o_match = addr_hit && byte_ok && dir_ok && space_ok;
    end

endmodule

`default_nettype wire

// ---- hw/chip_select_unit.sv ----
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none


module chip_select_unit (
    // clock and reset
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_rstn,
    // wishbone slave
    input  wire logic                                 i_wb_cyc,
    input  wire logic                                 i_wb_stb,
    input  wire logic                                 i_wb_we,
    input  wire logic [chip_select_pkg::WB_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]                           i_wb_sel,
    input  wire logic [31:0]                          i_wb_dat,
    output logic      [31:0]                          o_wb_dat,
    output logic                                      o_wb_ack,
    // internal bus cycle
    input  wire logic [chip_select_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic                                 i_read,
    input  wire logic [1:0]                           i_space,
    input  wire logic                                 i_iack,
    input  wire logic                                 i_upper_lane,
    input  wire logic                                 i_lower_lane,
    input  wire logic                                 i_address_strobe_n,
    input  wire logic                                 i_data_strobe_n,
    input  wire logic                                 i_e_clock,
    input  wire logic                                 i_internal_hit,
    // pin configuration
    input  wire logic [chip_select_pkg::CH_COUNT-1:0] i_port16,
    input  wire logic [chip_select_pkg::CH_COUNT-1:0] i_discrete_pins,
    // pin and bus answers
    output logic      [chip_select_pkg::CH_COUNT-1:0] o_select_pin_n,
    output logic                                      o_data_size_acknowledge_n,
    output logic                                      o_autovector_response_n,
    output logic                                      o_e_clock_pending
);
    import chip_select_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [CH_COUNT-1:0][15:0] base;       // select_base_and_size per channel
        logic [CH_COUNT-1:0][15:0] opts;       // select_options, boot at index 0
        logic [PORT_BITS-1:0]      port;       // discrete_output_port data
        logic                      wb_ack;     // bus answer
        logic [31:0]               wb_dat;     // registered read data
        logic [CH_COUNT-1:0]       pin_n;      // pin levels, select or discrete
        logic                      data_size_acknowledge_n;    // internal acknowledge
        logic                      autovector_response_n;     // internal autovector
        logic                      pending;    // e-clock cycle pending
        logic                      in_cycle;   // address strobe seen last edge
        logic [ACK_W-1:0]          count;      // cycles since strobe assertion
    } state_t;

    state_t              st;          // registered state
    state_t              next_st;     // next value
    logic [CH_COUNT-1:0] match;       // per-channel qualified match
    logic [CH_COUNT-1:0] timing_ok;   // per-channel strobe timing
    logic [CH_COUNT-1:0] select_on;   // per-channel select wanted
    logic [IDX_W-1:0]    first;       // lowest matching channel
    logic [15:0]         first_opts;  // its options
    logic [4:0]          reg_ch;      // channel addressed on the bus
    logic                bus_hit;     // new wishbone request
    logic                as_on;       // address strobe asserted
    logic                ds_on;       // data strobe asserted
    logic                ack_now;     // internal acknowledge condition

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // lowest set bit; zero when nothing is set, callers also test the vector
    function automatic logic [IDX_W-1:0] lowest(input logic [CH_COUNT-1:0] v);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int c = CH_COUNT - 1; c >= 0; c--) begin
            if (v[c]) begin
                idx = IDX_W'(c);
            end
        end
        return idx;
    endfunction

    // byte-lane merge of a 16-bit register write
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    // ------------------------------------------------------------------------
    // channel match logic
    // ------------------------------------------------------------------------
    // every channel compares even when its pin is discrete or alternate
    generate
        for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
            chip_select_channel u_ch (
                .i_base       (st.base[g]),
                .i_options    (st.opts[g]),
                .i_port16     (i_port16[g]),
                .i_addr       (i_addr),
                .i_read       (i_read),
                .i_space      (i_space),
                .i_iack       (i_iack),
                .i_upper_lane (i_upper_lane),
                .i_lower_lane (i_lower_lane),
                .o_match      (match[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        as_on   = !i_address_strobe_n;
        ds_on   = !i_data_strobe_n;
        reg_ch  = i_wb_adr[WB_ADR_W-1:REG_STRIDE_SHIFT];
        bus_hit = i_wb_cyc && i_wb_stb && !st.wb_ack;

        // wishbone: answer one cycle after the request, drop the next cycle
        next_st.wb_ack = bus_hit;
        if (bus_hit) begin
            next_st.wb_dat = '0;          // unmapped addresses read zero
            if (int'(reg_ch) < CH_COUNT) begin
                if (i_wb_adr[REG_OPT_BIT]) begin
                    next_st.wb_dat[15:0] = st.opts[reg_ch];
                    if (i_wb_we) begin
                        next_st.opts[reg_ch] = merge16(st.opts[reg_ch], i_wb_dat, i_wb_sel);
                    end
                end else begin
                    next_st.wb_dat[15:0] = st.base[reg_ch];
                    if (i_wb_we) begin
                        next_st.base[reg_ch] = merge16(st.base[reg_ch], i_wb_dat, i_wb_sel);
                    end
                end
            end else if (i_wb_adr == REG_PORT) begin
                // top bit of the byte is not stored and reads zero
                next_st.wb_dat[PORT_BITS-1:0] = st.port;
                if (i_wb_we && i_wb_sel[0]) begin
                    next_st.port = i_wb_dat[PORT_BITS-1:0];
                end
            end else if (i_wb_adr == REG_STATUS) begin
                next_st.wb_dat[CH_COUNT-1:0]   = ~st.pin_n;
                next_st.wb_dat[STAT_DATA_SIZE_ACKNOWLEDGE_BIT] = !st.data_size_acknowledge_n;
                next_st.wb_dat[STAT_AUTOVECTOR_RESPONSE_BIT]  = !st.autovector_response_n;
                next_st.wb_dat[STAT_PENDING_BIT] = st.pending;
            end
        end

        // cycle counter; saturates so a long cycle keeps its acknowledge
        next_st.in_cycle = as_on;
        if (!as_on || !st.in_cycle) begin
            next_st.count = '0;
        end else if (st.count != COUNT_MAX) begin
            next_st.count = ACK_W'(st.count + 4'h1);
        end

        // per-channel timing and select
        for (int c = 0; c < CH_COUNT; c++) begin
            if (st.opts[c][OPT_MODE_BIT]) begin
                timing_ok[c] = as_on && i_e_clock;
            end else if (st.opts[c][OPT_STROBE_CHOICE_BIT]) begin
                timing_ok[c] = ds_on;
            end else begin
                timing_ok[c] = as_on;
            end
            // an on-chip resource owns the address; selects negate with strobe
            select_on[c] = match[c] && timing_ok[c] && !i_internal_hit;
            next_st.pin_n[c] = !select_on[c];
            if (i_discrete_pins[c] && c >= DISCRETE_BASE && c < DISCRETE_BASE + PORT_BITS) begin
                next_st.pin_n[c] = st.port[c - DISCRETE_BASE];
            end
        end

        // synchronous channels tell the bus interface an e-clock cycle waits
        next_st.pending = 1'b0;
        for (int c = 0; c < CH_COUNT; c++) begin
            if (match[c] && st.opts[c][OPT_MODE_BIT] && as_on && !i_internal_hit) begin
                next_st.pending = 1'b1;
            end
        end

        // acknowledge source is the lowest matching channel
        first      = lowest(match);
        first_opts = st.opts[first];
        ack_now    = 1'b0;
        if (first_opts[OPT_ACK_LO +: ACK_W] == ACK_FAST) begin
            ack_now = as_on;
        end else if (first_opts[OPT_ACK_LO +: ACK_W] != ACK_EXTERNAL) begin
            ack_now = as_on && st.in_cycle &&
                      (st.count >= first_opts[OPT_ACK_LO +: ACK_W]);
        end
        next_st.data_size_acknowledge_n = 1'b1;
        next_st.autovector_response_n  = 1'b1;
        if ((|match) && !i_internal_hit) begin
            if ((first_opts[OPT_SPACE_LO +: 2] == SPACE_CPU) && first_opts[OPT_AUTOVECTOR_RESPONSE_BIT]) begin
                next_st.autovector_response_n = !(as_on && i_iack);
            end else if (!first_opts[OPT_MODE_BIT]) begin
                next_st.data_size_acknowledge_n = !ack_now;
            end
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < CH_COUNT; c++) begin
                st.base[c] <= BASE_RESET;
                st.opts[c] <= OPT_RESET;     // reserved direction code keeps selects quiet
            end
            st.base[0]  <= BOOT_BASE_RESET;
            st.opts[0]  <= BOOT_OPT_RESET;
            st.port     <= PORT_RESET;
            st.wb_ack   <= 1'b0;
            st.wb_dat   <= '0;
            st.pin_n    <= '1;
            st.data_size_acknowledge_n  <= 1'b1;
            st.autovector_response_n   <= 1'b1;
            st.pending  <= 1'b0;
            st.in_cycle <= 1'b0;
            st.count    <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------------
    assign o_wb_dat                  = st.wb_dat;
    assign o_wb_ack                  = st.wb_ack;
    assign o_select_pin_n            = st.pin_n;
    assign o_data_size_acknowledge_n = st.data_size_acknowledge_n;
    assign o_autovector_response_n   = st.autovector_response_n;
    assign o_e_clock_pending            = st.pending;

endmodule

`default_nettype wire

// ---- verif/chip_select_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// port-level checks of the chip-select unit
// ---------------------------------------------
module chip_select_checker
    import chip_select_pkg::*;
(
    input wire logic                i_mclk, i_rstn, i_wb_cyc, i_wb_stb, o_wb_ack, i_iack,
    input wire logic                i_address_strobe_n, i_data_strobe_n, i_internal_hit,
    input wire logic                o_data_size_acknowledge_n, o_autovector_response_n,
    input wire logic                o_e_clock_pending,
    input wire logic [1:0]          i_space,
    input wire logic [CH_COUNT-1:0] i_discrete_pins, o_select_pin_n
);
    wire logic as_low = !i_address_strobe_n; // address strobe active
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    sequence s_take; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
    sequence s_pulse; o_wb_ack ##1 !o_wb_ack; endsequence
    // all answers negated; discrete pins carry port data, so masked
    sequence s_idle;
        &(o_select_pin_n | $past(i_discrete_pins)) && o_data_size_acknowledge_n
            && o_autovector_response_n && !o_e_clock_pending;
    endsequence
    chk_bus_answer: assert property (s_take |=> s_pulse) else $error("bad bus ack");
    chk_no_stray: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("stray bus ack");
    chk_release_idle: assert property (
        !as_low && i_data_strobe_n |=> s_idle) else $error("not idle after strobes");
    chk_hit_blocks: assert property (
        i_internal_hit |=> s_idle) else $error("answer despite on-chip hit");
    chk_data_size_acknowledge_cause: assert property (
        !o_data_size_acknowledge_n |-> $past(as_low && !i_internal_hit)) else $error("stray data_size_acknowledge");
    chk_autovector_response_cause: assert property (
        !o_autovector_response_n |-> $past(as_low && i_iack && i_space == SPACE_CPU))
        else $error("stray autovector");
    chk_pending_cause: assert property (
        o_e_clock_pending |-> $past(as_low && !i_internal_hit)) else $error("stray pending");
    chk_autovector_response_no_data_size_acknowledge: assert property (
        !o_autovector_response_n |-> o_data_size_acknowledge_n) else $error("two answers");
endmodule
bind chip_select_unit chip_select_checker u_chk (.*);
`default_nettype wire

// ---- verif/chip_select_memory.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// external memory sitting on one select pin
// ---------------------------------------------
module chip_select_memory (
    input  wire logic i_mclk,     // clock
    input  wire logic i_select_n, // its select, active low
    output logic      o_ack_n     // own acknowledge, pulled up when idle
);
    logic [1:0] wait_count; // edges seen while selected
    // answers on the second edge; pull-up takes it high once released
    always_ff @(posedge i_mclk)
        wait_count <= i_select_n ? 2'h0 : wait_count + {1'b0, wait_count != 2'h2};
    assign o_ack_n = wait_count != 2'h2;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import chip_select_pkg::*;
    logic        i_mclk = 0, i_rstn = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, ext_n;
    logic        i_read = 0, i_upper_lane = 0, i_lower_lane = 0, i_e_clock = 0, m, av;
    logic        i_address_strobe_n = 1, i_data_strobe_n = 1, i_internal_hit = 0, o_wb_ack;
    logic        o_data_size_acknowledge_n, o_autovector_response_n, o_e_clock_pending;
    logic [7:0]  i_wb_adr = 8'h00;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rv, r, ep, fp, fd, fa, fe, fx;
    logic [23:0] i_addr = 24'h0, a;
    logic [15:0] o, base;
    logic [1:0]  i_space = 2'h1;
    logic [11:0] o_select_pin_n;
    int          err_count = 0, comparisons = 0, seed = 5, lsb;
    initial forever #5 i_mclk = !i_mclk;
    chip_select_unit dut (.*, .i_wb_sel(4'h3), .i_iack(i_space == SPACE_CPU),
        .i_port16(12'hfff), .i_discrete_pins(12'h7f0));
    chip_select_memory far_end (.i_mclk, .i_select_n(o_select_pin_n[1]), .o_ack_n(ext_n));
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (e !== g) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge i_mclk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, ad, d};
        do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
        rv = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'h0;
    endtask
    // expected qualification of channel 1 for the current access
    function automatic logic match(input logic [15:0] v);
        logic q;
        // both-bytes code selects whatever lanes the access carries
        q = (i_read ? v[11] : v[12])
            && (v[14:13] == 2'h3 || |(v[14:13] & {i_upper_lane, i_lower_lane}));
        if (v[5:4] == SPACE_CPU)
            return q && !i_internal_hit && i_space == SPACE_CPU
                && (v[3:1] == IPL_ANY || v[3:1] == i_addr[3:1]);
        return q && !i_internal_hit && |(v[5:4] & i_space);
    endfunction
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rstn <= 1;
        bus(0, 8'h04, 0);
        chk("boot options", 32'h7b70, rv);
        r = $random(seed) | 32'h80;
        bus(1, REG_PORT, r);
        bus(0, REG_PORT, 0);
        chk("port read", r[6:0], rv);
        chk("port pins", r[6:0], o_select_pin_n[10:4]);
        bus(0, 8'h70, 0);
        chk("unmapped", 0, rv);
        repeat (40) begin
            r = $random(seed);
            o = $random(seed);
            if (o[15]) o[0] = 0;
            a = $random(seed) | 24'h800000; // clear of the boot block
            lsb = SIZE_LOW_BIT[r[2:0]];
            base = {a[23:11] >> (lsb - 11) << (lsb - 11), r[2:0]};
            if (r[3]) a[lsb] = !a[lsb];
            else a[lsb - 1] = !a[lsb - 1];
            {i_read, i_upper_lane, i_lower_lane, i_e_clock} <= r[7:4];
            i_space <= r[9:8] == 2'h3 ? SPACE_USER : r[9:8];
            i_internal_hit <= r[12:10] == 3'h0;
            i_addr <= a;
            bus(1, 8'h08, base);
            bus(1, 8'h0c, o);
            bus(0, 8'h08, 0);
            chk("base", base, rv);
            @(posedge i_mclk);
            i_address_strobe_n <= 0;
            {fp, fd, fa, fe, fx} = '0;
            for (int i = 1; i < 19; i++) begin
                @(posedge i_mclk);
                i_data_strobe_n <= 0;
                #1;
                if (o_select_pin_n[1] === 0 && fp == 0) fp = i;
                if (o_data_size_acknowledge_n === 0 && fd == 0) fd = i;
                if (o_autovector_response_n === 0 && fa == 0) fa = i;
                if (o_e_clock_pending === 1 && fe == 0) fe = i;
                if (ext_n === 0 && fx == 0) fx = i;
            end
            m = match(o) && !r[3];
            av = m && o[5:4] == SPACE_CPU && o[0];
            ep = !m ? 0 : o[15] ? i_e_clock : o[10] ? 2 : 1;
            chk("select", ep, fp);
            chk("far ack", ep ? ep + 2 : 0, fx);
            chk("autovector", av, fa);
            chk("pending", m && o[15], fe);
            ep = o[9:6] == ACK_FAST ? 1 : o[9:6] + 2;
            chk("data_size_acknowledge", m && !o[15] && !av && o[9:6] != ACK_EXTERNAL ? ep : 0, fd);
            @(posedge i_mclk);
            {i_address_strobe_n, i_data_strobe_n} <= 2'h3;
            repeat (2) @(posedge i_mclk);
        end
        final_report;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
